// ### iocpa_fifo.sv
// Synchronous FIFO with valid/ready on both sides
module iocpa_fifo #(
	parameter int WIDTH = 35,
	parameter int DEPTH = 32
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_wr_valid,
	output logic o_wr_ready,
	input wire logic [WIDTH-1:0] i_wr_data,
	output logic o_rd_valid,
	input wire logic i_rd_ready,
	output logic [WIDTH-1:0] o_rd_data
);
	localparam int PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [PTR_W:0] wr_ptr_reg;
	logic [PTR_W:0] rd_ptr_reg;
	logic full;
	logic empty;
	logic do_wr;
	logic do_rd;

	// Extra pointer bit tells full from empty when the indices meet
	assign full = (wr_ptr_reg[PTR_W] != rd_ptr_reg[PTR_W]) && (wr_ptr_reg[PTR_W-1:0] == rd_ptr_reg[PTR_W-1:0]);
	assign empty = (wr_ptr_reg == rd_ptr_reg);
	assign do_wr = i_wr_valid && !full;
	assign do_rd = i_rd_ready && !empty;
	assign o_wr_ready = !full;
	assign o_rd_valid = !empty;
	assign o_rd_data = mem[rd_ptr_reg[PTR_W-1:0]];

	always_ff @(posedge i_clk) begin
		if (do_wr) begin
			mem[wr_ptr_reg[PTR_W-1:0]] <= i_wr_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (do_rd) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end
endmodule

// ### iocpa_mem_model.sv
// Core storage model answering the block's storage port
module iocpa_mem_model
	import iocpa_pkg::*;
#(
	parameter int LAT = 3
) (
	input wire logic i_clk,
	input wire logic i_mem_req,
	input wire logic i_mem_we,
	input wire logic [ADDR_W-1:0] i_mem_addr,
	input wire logic [WORD_W-1:0] i_mem_wdata,
	output logic [WORD_W-1:0] o_mem_rdata,
	output logic o_mem_ack
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [ADDR_W-1:0] last_addr = '0;
	logic [WORD_W-1:0] last_wdata = '0;
	int cnt = 0;
	initial o_mem_ack = 1'b0;
	initial o_mem_rdata = '0;
	always @(posedge i_clk) begin
		o_mem_ack <= 1'b0;
		// Read data means nothing without ack, so it keeps toggling
		o_mem_rdata <= ~o_mem_rdata;
		if (i_mem_req && !o_mem_ack) begin
			cnt <= cnt + 1;
			if (cnt >= LAT) begin
				cnt <= 0;
				o_mem_ack <= 1'b1;
				o_mem_rdata <= {i_mem_addr ^ 15'h1234, i_mem_addr};
				if (i_mem_we) begin
					last_addr <= i_mem_addr;
					last_wdata <= i_mem_wdata;
				end
			end
		end
	end
endmodule

// ### iocpa_monitor.sv
// Checker for the channel priority and storage access block
module iocpa_monitor
	import iocpa_pkg::*;
#(
	parameter int N_CH = NUM_CH
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_act_valid,
	input wire logic [CHAN_W-1:0] i_act_chan,
	input wire logic o_act_ok,
	input wire logic o_act_refused,
	input wire logic [N_CH-1:0] o_in_ack,
	input wire logic o_mem_req,
	input wire logic o_mem_we,
	input wire logic [ADDR_W-1:0] o_mem_addr,
	input wire logic i_mem_ack,
	input wire logic [WORD_W-1:0] o_gen_bank0,
	input wire logic [WORD_W-1:0] o_gen_bank1,
	input wire logic [WORD_W-1:0] o_gen_bank2
);
	// Cycles since the last storage request rose; saturates so reset start reads as long ago
	logic [CYC_W-1:0] gap_reg;
	logic req_reg;
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			gap_reg <= '1;
			req_reg <= 1'b0;
		end else begin
			req_reg <= o_mem_req;
			if (o_mem_req && !req_reg) begin
				gap_reg <= '0;
			end else if (gap_reg != '1) begin
				gap_reg <= gap_reg + 1'b1;
			end
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	a_act_answer: assert property (i_act_valid |=> o_act_ok != o_act_refused)
		else $error("activation not answered once");
	a_answer_cause: assert property (o_act_ok || o_act_refused |-> $past(i_act_valid))
		else $error("activation answer without request");
	a_bad_chan: assert property (i_act_valid && i_act_chan >= CHAN_W'(N_CH) |=> o_act_refused)
		else $error("channel out of range accepted");
	a_one_grant: assert property ($onehot0(o_in_ack))
		else $error("two input acks at once");
	a_ack_cause: assert property (|o_in_ack |-> $past(i_mem_ack && o_mem_we))
		else $error("input ack without storage write");
	a_req_hold: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_we))
		else $error("storage request changed before ack");
	a_req_drop: assert property (o_mem_req && i_mem_ack |=> !o_mem_req)
		else $error("storage request held after ack");
	a_banks_same: assert property (o_gen_bank1 == o_gen_bank0 && o_gen_bank2 == o_gen_bank0)
		else $error("driver banks differ");
	a_grant_space: assert property ($rose(o_mem_req) |-> gap_reg >= STORE_CYCLES_M1)
		else $error("storage cycles overlap");
	cover property (|o_in_ack);
	cover property (o_act_refused);
	cover property (o_mem_req && !o_mem_we && i_mem_ack);
endmodule

bind iocpa_top iocpa_monitor #(.N_CH(N_CH)) u_mon (
	.i_clk(i_clk),
	.i_reset_n(i_reset_n),
	.i_act_valid(i_act_valid),
	.i_act_chan(i_act_chan),
	.o_act_ok(o_act_ok),
	.o_act_refused(o_act_refused),
	.o_in_ack(o_in_ack),
	.o_mem_req(o_mem_req),
	.o_mem_we(o_mem_we),
	.o_mem_addr(o_mem_addr),
	.i_mem_ack(i_mem_ack),
	.o_gen_bank0(o_gen_bank0),
	.o_gen_bank1(o_gen_bank1),
	.o_gen_bank2(o_gen_bank2)
);

// ### iocpa_pkg.sv
// Shared constants and types for the I/O channel priority and access block
package iocpa_pkg;
	// ****************************************
	// Channel and word geometry
	// ****************************************
	localparam int NUM_CH = 14;
	localparam int WORD_W = 30;
	localparam int ADDR_W = 15;
	localparam int CHAN_W = 4;
	localparam int IC_CHANS = 2;
	localparam int GEN_BANKS = 3;
	localparam int BANK_FANOUT = 4;
	localparam int NUM_SLOTS = 2 * NUM_CH;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int STORE_CYCLE_NS = 8000;
	// Least time: round up to whole clock cycles
	localparam int STORE_CYCLES = (STORE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_W = 10;
	localparam logic [CYC_W-1:0] STORE_CYCLES_M1 = CYC_W'(STORE_CYCLES - 1);

	// ****************************************
	// Buffering
	// ****************************************
	localparam int FIFO_DEPTH = 32;
	// Entry: function flag, channel number, word
	localparam int FIFO_W = 1 + CHAN_W + WORD_W;
	localparam int FE_WORD_LSB = 0;
	localparam int FE_CHAN_LSB = WORD_W;
	localparam int FE_FUNC_BIT = WORD_W + CHAN_W;

	// ****************************************
	// Transfer direction and storage cycle state
	// ****************************************
	localparam logic DIR_OUT = 1'b0;
	localparam logic DIR_IN = 1'b1;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ACCESS = 2'b01,
		ST_RESTORE = 2'b10
	} iocpa_state_e;
endpackage

// ### iocpa_top.sv
// Channel priority and storage access logic for the I/O section
// ****************************************
// What this block does
// - Fourteen input, fourteen output thirty-bit channels
// - Channels 0 and 1 reserved for intercomputer
// - General output register loaded from storage
// - Three driver banks, each feeding four channels
// - Intercomputer register drives its two channels
// - Highest-numbered output channel served first
// - Highest-numbered input channel gated first
// - Intercomputer channels get the lowest priority
// - Input words go straight to storage
// - Device paces blocks; storage access independent
// - Link set up by request/response exchange
// - Established link runs without program help
// - Output words may be function commands
// - Over thirty thousand words per second
// - Each word stored in one storage cycle
// - Busy channel refuses a new link
// - Control word advanced during restore phase
// - Current equals terminal ends the transfer
// ****************************************
module iocpa_top
	import iocpa_pkg::*;
#(
	parameter int N_CH = NUM_CH,
	parameter int FDEPTH = FIFO_DEPTH
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Channel request lines
	input wire logic [N_CH-1:0] i_in_req,
	input wire logic [N_CH-1:0][WORD_W-1:0] i_in_data,
	output logic [N_CH-1:0] o_in_ack,
	input wire logic [N_CH-1:0] i_out_req,
	output logic [N_CH-1:0] o_out_ack,
	output logic [N_CH-1:0] o_out_func,
	output logic [WORD_W-1:0] o_gen_bank0,
	output logic [WORD_W-1:0] o_gen_bank1,
	output logic [WORD_W-1:0] o_gen_bank2,
	output logic [WORD_W-1:0] o_ic_word,
	// Requests seen on channels that have no link yet
	output logic [N_CH-1:0] o_in_attn,
	output logic [N_CH-1:0] o_out_attn,
	output logic [N_CH-1:0] o_in_active,
	output logic [N_CH-1:0] o_out_active,
	// Program side link activation
	input wire logic i_act_valid,
	input wire logic i_act_dir,
	input wire logic [CHAN_W-1:0] i_act_chan,
	input wire logic i_act_func,
	input wire logic [ADDR_W-1:0] i_act_first,
	input wire logic [ADDR_W-1:0] i_act_last,
	output logic o_act_ok,
	output logic o_act_refused,
	// Core storage port
	output logic o_mem_req,
	output logic o_mem_we,
	output logic [ADDR_W-1:0] o_mem_addr,
	output logic [WORD_W-1:0] o_mem_wdata,
	input wire logic [WORD_W-1:0] i_mem_rdata,
	input wire logic i_mem_ack
);
	// ****************************************
	// Reset release
	// ****************************************
	logic rst_meta_reg;
	logic rst_n_reg;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg <= rst_meta_reg;
		end
	end

	// ****************************************
	// Channel state
	// ****************************************
	// Slot index: direction * N_CH + channel
	logic [ADDR_W-1:0] cur_reg [0:2*N_CH-1];
	logic [ADDR_W-1:0] term_reg [0:2*N_CH-1];
	logic [2*N_CH-1:0] active_reg;
	logic [N_CH-1:0] func_reg;
	logic [N_CH-1:0] in_served_reg;
	logic [N_CH-1:0] out_served_reg;
	logic [N_CH-1:0] in_pend;
	logic [N_CH-1:0] out_pend;

	iocpa_state_e state_reg;
	logic [CYC_W-1:0] timer_reg;
	logic g_dir_reg;
	logic [CHAN_W-1:0] g_chan_reg;
	logic [ADDR_W-1:0] g_slot_cur;
	logic [ADDR_W-1:0] g_slot_term;
	logic [CHAN_W:0] g_slot;

	logic pick_found;
	logic pick_dir;
	logic [CHAN_W-1:0] pick_chan;
	logic [CHAN_W:0] act_slot;
	logic [CHAN_W:0] pick_slot;
	logic act_busy;
	logic grant;

	logic fifo_wr_valid;
	logic fifo_wr_ready;
	logic [FIFO_W-1:0] fifo_wr_data;
	logic fifo_rd_valid;
	logic fifo_rd_ready;
	logic [FIFO_W-1:0] fifo_rd_data;
	logic [CHAN_W-1:0] head_chan;
	logic head_ic;
	logic gen_busy;
	logic ic_busy;

	// ****************************************
	// Pending requests, one set per channel
	// ****************************************
	genvar c;
	generate
		for (c = 0; c < N_CH; c++) begin : g_chan
			// A request stays pending until granted; served marks hold off regrants
			assign in_pend[c] = i_in_req[c] && active_reg[N_CH + c] && !in_served_reg[c];
			assign out_pend[c] = i_out_req[c] && active_reg[c] && !out_served_reg[c];

			always_ff @(posedge i_clk or negedge rst_n_reg) begin
				if (!rst_n_reg) begin
					in_served_reg[c] <= 1'b0;
					out_served_reg[c] <= 1'b0;
					o_in_attn[c] <= 1'b0;
					o_out_attn[c] <= 1'b0;
					o_out_ack[c] <= 1'b0;
				end else begin
					// Device must drop its request before the next word
					if (!i_in_req[c]) begin
						in_served_reg[c] <= 1'b0;
					end else if (grant && pick_dir == DIR_IN && pick_chan == CHAN_W'(c)) begin
						in_served_reg[c] <= 1'b1;
					end
					if (!i_out_req[c]) begin
						out_served_reg[c] <= 1'b0;
					end else if (grant && pick_dir == DIR_OUT && pick_chan == CHAN_W'(c)) begin
						out_served_reg[c] <= 1'b1;
					end
					// External side asks for a link the program has not yet set up
					o_in_attn[c] <= i_in_req[c] && !active_reg[N_CH + c];
					o_out_attn[c] <= i_out_req[c] && !active_reg[c];
					// Ack marks the one channel whose receiver may take the word
					if (fifo_rd_valid && fifo_rd_ready && head_chan == CHAN_W'(c)) begin
						o_out_ack[c] <= 1'b1;
					end else if (!i_out_req[c]) begin
						o_out_ack[c] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// ****************************************
	// Priority pick
	// ****************************************
	// Ascending scan lets the highest channel win; input beats output on a tie
	always_comb begin
		pick_found = 1'b0;
		pick_dir = DIR_OUT;
		pick_chan = '0;
		for (int i = 0; i < N_CH; i++) begin
			if (out_pend[i]) begin
				pick_found = 1'b1;
				pick_dir = DIR_OUT;
				pick_chan = CHAN_W'(i);
			end
			if (in_pend[i]) begin
				pick_found = 1'b1;
				pick_dir = DIR_IN;
				pick_chan = CHAN_W'(i);
			end
		end
	end

	// Channels 0 and 1 sit at the bottom of the scan
	assign pick_slot = {pick_dir, 4'h0} + (pick_dir ? 5'(N_CH) : 5'h00) - {pick_dir, 4'h0} + {1'b0, pick_chan};
	assign act_slot = (i_act_dir ? 5'(N_CH) : 5'h00) + {1'b0, i_act_chan};
	assign g_slot = (g_dir_reg ? 5'(N_CH) : 5'h00) + {1'b0, g_chan_reg};
	assign g_slot_cur = cur_reg[g_slot];
	assign g_slot_term = term_reg[g_slot];
	assign act_busy = active_reg[act_slot];

	// Outputs need a free FIFO slot before storage is read
	assign grant = (state_reg == ST_IDLE) && (timer_reg == '0) && pick_found
		&& (pick_dir == DIR_IN || fifo_wr_ready);

	// ****************************************
	// Storage cycle sequencer
	// ****************************************
	always_ff @(posedge i_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			state_reg <= ST_IDLE;
			timer_reg <= '0;
			g_dir_reg <= DIR_OUT;
			g_chan_reg <= '0;
			o_mem_req <= 1'b0;
			o_mem_we <= 1'b0;
			o_mem_addr <= '0;
			o_mem_wdata <= '0;
			o_in_ack <= '0;
		end else begin
			o_in_ack <= '0;
			if (timer_reg != '0) begin
				timer_reg <= timer_reg - 1'b1;
			end
			case (state_reg)
				ST_IDLE: begin
					if (grant) begin
						// Whole storage cycle is timed from here; no program involvement
						timer_reg <= STORE_CYCLES_M1;
						g_dir_reg <= pick_dir;
						g_chan_reg <= pick_chan;
						o_mem_req <= 1'b1;
						o_mem_we <= pick_dir;
						o_mem_addr <= cur_reg[pick_slot];
						// Receivers feed the storage write port directly
						o_mem_wdata <= i_in_data[pick_chan];
						state_reg <= ST_ACCESS;
					end
				end
				ST_ACCESS: begin
					if (i_mem_ack) begin
						o_mem_req <= 1'b0;
						if (g_dir_reg == DIR_IN) begin
							o_in_ack[g_chan_reg] <= 1'b1;
						end
						state_reg <= ST_RESTORE;
					end
				end
				ST_RESTORE: begin
					state_reg <= ST_IDLE;
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Control words and link activation
	// ****************************************
	always_ff @(posedge i_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			active_reg <= '0;
			func_reg <= '0;
			o_act_ok <= 1'b0;
			o_act_refused <= 1'b0;
			for (int i = 0; i < 2 * N_CH; i++) begin
				cur_reg[i] <= '0;
				term_reg[i] <= '0;
			end
		end else begin
			o_act_ok <= 1'b0;
			o_act_refused <= 1'b0;
			if (state_reg == ST_RESTORE) begin
				// Advance the current address while the word is restored
				cur_reg[g_slot] <= g_slot_cur + 1'b1;
				if (g_slot_cur + 1'b1 == g_slot_term) begin
					active_reg[g_slot] <= 1'b0;
				end
			end
			if (i_act_valid && i_act_chan < CHAN_W'(N_CH)) begin
				if (act_busy || (state_reg != ST_IDLE && g_slot == act_slot)) begin
					o_act_refused <= 1'b1;
				end else begin
					cur_reg[act_slot] <= i_act_first;
					term_reg[act_slot] <= i_act_last;
					// Empty block needs no link at all
					active_reg[act_slot] <= (i_act_first != i_act_last);
					if (i_act_dir == DIR_OUT) begin
						func_reg[i_act_chan] <= i_act_func;
					end
					o_act_ok <= 1'b1;
				end
			end else if (i_act_valid) begin
				o_act_refused <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			o_in_active <= '0;
			o_out_active <= '0;
		end else begin
			o_in_active <= active_reg[2*N_CH-1:N_CH];
			o_out_active <= active_reg[N_CH-1:0];
		end
	end

	// ****************************************
	// Output word path
	// ****************************************
	// The FIFO decouples the storage cycle from slow receivers at the cost of latency
	assign fifo_wr_valid = (state_reg == ST_ACCESS) && i_mem_ack && (g_dir_reg == DIR_OUT);
	assign fifo_wr_data = {func_reg[g_chan_reg], g_chan_reg, i_mem_rdata};
	assign head_chan = fifo_rd_data[FE_CHAN_LSB +: CHAN_W];
	assign head_ic = head_chan < CHAN_W'(IC_CHANS);
	assign ic_busy = |o_out_ack[IC_CHANS-1:0];
	assign gen_busy = |o_out_ack[N_CH-1:IC_CHANS];
	// Each register waits until its receiver drops the request
	assign fifo_rd_ready = head_ic ? !ic_busy : !gen_busy;

	iocpa_fifo #(
		.WIDTH(FIFO_W),
		.DEPTH(FDEPTH)
	) u_fifo (
		.i_clk(i_clk),
		.i_rst_n(rst_n_reg),
		.i_wr_valid(fifo_wr_valid),
		.o_wr_ready(fifo_wr_ready),
		.i_wr_data(fifo_wr_data),
		.o_rd_valid(fifo_rd_valid),
		.i_rd_ready(fifo_rd_ready),
		.o_rd_data(fifo_rd_data)
	);

	always_ff @(posedge i_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			o_gen_bank0 <= '0;
			o_gen_bank1 <= '0;
			o_gen_bank2 <= '0;
			o_ic_word <= '0;
			o_out_func <= '0;
		end else if (fifo_rd_valid && fifo_rd_ready) begin
			o_out_func <= '0;
			o_out_func[head_chan] <= fifo_rd_data[FE_FUNC_BIT];
			if (head_ic) begin
				o_ic_word <= fifo_rd_data[FE_WORD_LSB +: WORD_W];
			end else begin
				// Same word on every bank; each bank fans out to four channels
				o_gen_bank0 <= fifo_rd_data[FE_WORD_LSB +: WORD_W];
				o_gen_bank1 <= fifo_rd_data[FE_WORD_LSB +: WORD_W];
				o_gen_bank2 <= fifo_rd_data[FE_WORD_LSB +: WORD_W];
			end
		end
	end
	// Fourteen channels each way, thirty lines each, set by the port widths
	// One word per 8 us cycle is 125k words/s, well above the required rate
endmodule

// ### tb_top.sv
// Testbench for the channel priority and storage access block
module tb_top;
	import iocpa_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, reset_n, act_valid, act_dir, act_func, act_ok, act_ref, mem_req, mem_we, mem_ack;
	logic [NUM_CH-1:0] in_req, out_req, in_ack, out_ack, out_func, in_attn, out_attn, in_act, out_act;
	logic [NUM_CH-1:0][WORD_W-1:0] in_data;
	logic [WORD_W-1:0] bank0, bank1, bank2, ic_word, mem_wdata, mem_rdata;
	logic [CHAN_W-1:0] act_chan;
	logic [ADDR_W-1:0] act_first, act_last, mem_addr;
	int num_errors = 0;
	int samples_checked = 0;
	iocpa_top #(.N_CH(NUM_CH), .FDEPTH(FIFO_DEPTH)) DUT (
		.i_clk(clk), .i_reset_n(reset_n),
		.i_in_req(in_req), .i_in_data(in_data), .o_in_ack(in_ack),
		.i_out_req(out_req), .o_out_ack(out_ack), .o_out_func(out_func),
		.o_gen_bank0(bank0), .o_gen_bank1(bank1), .o_gen_bank2(bank2), .o_ic_word(ic_word),
		.o_in_attn(in_attn), .o_out_attn(out_attn), .o_in_active(in_act), .o_out_active(out_act),
		.i_act_valid(act_valid), .i_act_dir(act_dir), .i_act_chan(act_chan), .i_act_func(act_func),
		.i_act_first(act_first), .i_act_last(act_last), .o_act_ok(act_ok), .o_act_refused(act_ref),
		.o_mem_req(mem_req), .o_mem_we(mem_we), .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata),
		.i_mem_rdata(mem_rdata), .i_mem_ack(mem_ack)
	);
	iocpa_mem_model #(.LAT(2)) u_mem (
		.i_clk(clk), .i_mem_req(mem_req), .i_mem_we(mem_we), .i_mem_addr(mem_addr),
		.i_mem_wdata(mem_wdata), .o_mem_rdata(mem_rdata), .o_mem_ack(mem_ack)
	);
	function automatic logic [WORD_W-1:0] pat(logic [ADDR_W-1:0] a);
		return {a ^ 15'h1234, a};
	endfunction
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic activate(logic dir, logic [CHAN_W-1:0] ch, logic fn, logic [ADDR_W-1:0] first, last, logic ok);
		act_valid = 1'b1;
		act_dir = dir;
		act_chan = ch;
		act_func = fn;
		act_first = first;
		act_last = last;
		@(posedge clk);
		#1;
		act_valid = 1'b0;
		// Answer is a one-cycle pulse: look before the next edge clears it
		check("act ok", 32'(ok), 32'(act_ok));
		check("act refused", 32'(!ok), 32'(act_ref));
		@(posedge clk);
		#1;
	endtask
	// Acks, level on output and one-cycle pulses on input, are polled after each edge; the grant gap bounds the wait
	task automatic wait_ack(logic out, output int idx);
		idx = -1;
		for (int i = 0; i < 2000 && idx < 0; i++) begin
			@(posedge clk);
			#1;
			for (int c = 0; c < NUM_CH; c++) begin
				if ((out ? out_ack[c] : in_ack[c]) === 1'b1) idx = c;
			end
		end
	endtask
	// ****
	// Scenarios
	// ****
	task automatic test_activate;
		activate(DIR_OUT, 4'h9, 1'b1, 15'h000a, 15'h000b, 1'b1);
		activate(DIR_OUT, 4'h9, 1'b0, 15'h0000, 15'h0005, 1'b0);
		activate(DIR_IN, 4'he, 1'b0, 15'h0000, 15'h0005, 1'b0);
		activate(DIR_IN, 4'h8, 1'b0, 15'h0040, 15'h0040, 1'b1);
		// Requests on channels without a link only raise attention
		in_req = 14'h0008;
		out_req = 14'h0010;
		@(posedge clk);
		#1;
		check("out active 9", 32'h1, 32'(out_act[9]));
		check("in active 8", 32'h0, 32'(in_act[8]));
		check("in attn 3", 32'h1, 32'(in_attn[3]));
		check("out attn 4", 32'h1, 32'(out_attn[4]));
		in_req = '0;
		out_req = '0;
		$display("test_activate done");
	endtask
	task automatic test_in_priority;
		int order[3] = '{12, 5, 0};
		int idx, c;
		for (int i = 0; i < 3; i++) begin
			c = order[i];
			in_data[c] = 30'h15a5a000 | 30'(c);
			activate(DIR_IN, CHAN_W'(c), 1'b0, 15'(32 + c), 15'(33 + c), 1'b1);
		end
		in_req = 14'h1021;
		for (int i = 0; i < 3; i++) begin
			c = order[i];
			wait_ack(1'b0, idx);
			check("in grant", 32'(c), 32'(idx));
			in_req[c] = 1'b0;
			check("in addr", 32'(32 + c), 32'(u_mem.last_addr));
			check("in data", 32'(in_data[c]), 32'(u_mem.last_wdata));
		end
		repeat (3) @(posedge clk);
		#1;
		check("in active", 32'h0, 32'(in_act));
		$display("test_in_priority done");
	endtask
	task automatic take_out(int c, logic [WORD_W-1:0] exp, logic fn);
		int idx;
		wait_ack(1'b1, idx);
		check("out grant", 32'(c), 32'(idx));
		check("out word", 32'(exp), 32'(c < 2 ? ic_word : bank0));
		check("out func", 32'(fn), 32'(out_func[c]));
		out_req[c] = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		check("out ack low", 32'h0, 32'(out_ack[c]));
	endtask
	task automatic test_out;
		activate(DIR_OUT, 4'h1, 1'b0, 15'h0030, 15'h0032, 1'b1);
		out_req = 14'h0202;
		take_out(9, pat(15'h000a), 1'b1);
		take_out(1, pat(15'h0030), 1'b0);
		out_req[1] = 1'b1;
		take_out(1, pat(15'h0031), 1'b0);
		repeat (3) @(posedge clk);
		#1;
		check("out active", 32'h0, 32'(out_act));
		$display("test_out done");
	endtask
	task automatic test_done;
		$display("checks %0d, mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		test_done();
	end
	initial begin
		reset_n = 1'b0;
		act_valid = 1'b0;
		act_dir = 1'b0;
		act_func = 1'b0;
		act_chan = '0;
		act_first = '0;
		act_last = '0;
		in_req = '0;
		out_req = '0;
		in_data = '0;
		repeat (3) @(posedge clk);
		#1;
		reset_n = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		test_activate();
		test_in_priority();
		test_out();
		test_done();
	end
endmodule
